// File: logic/cwcs_pkg.sv
// Package: configuration word layout, oscillator modes and timing constants
`default_nettype none
package cwcs_pkg;

  // ==========================================================================
  // Configuration word
  localparam logic [13:0] CFG_WORD_ADDR     = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO      = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI      = 14'h3fff;
  localparam int          CFG_WIDTH         = 14;
  localparam logic [13:0] CFG_ERASED        = 14'h3fff;
  localparam int          CP_HI_MSB         = 13;
  localparam int          CP_HI_LSB         = 12;
  localparam int          BROWNOUT_VOLTAGE_SELECT_MSB          = 11;
  localparam int          BROWNOUT_VOLTAGE_SELECT_LSB          = 10;
  localparam int          CP_LO_MSB         = 9;
  localparam int          CP_LO_LSB         = 8;
  localparam int          UNIMPL_BIT        = 7;
  localparam int          BOR_EN_BIT        = 6;
  localparam int          RST_PIN_BIT       = 5;
  localparam int          PWR_DLY_N_BIT     = 4;
  localparam int          WDOG_EN_BIT       = 3;
  localparam int          OSC_MSB           = 2;
  localparam int          OSC_LSB           = 0;

  // ==========================================================================
  // Brown-out trip levels
  localparam logic [1:0] BOR_TRIP_4V5 = 2'h0;
  localparam logic [1:0] BOR_TRIP_4V2 = 2'h1;
  localparam logic [1:0] BOR_TRIP_2V7 = 2'h2;
  localparam logic [1:0] BOR_TRIP_2V5 = 2'h3;
  localparam logic [3:0] TRIP_LEVEL_DV = 4'h0;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL  = 3'h0,
    OSC_STD_CRYSTAL        = 3'h1,
    OSC_HIGH_SPEED_CRYSTAL = 3'h2,
    OSC_EXT_CLOCK_IN       = 3'h3,
    OSC_INTERNAL_RC_IO     = 3'h4,
    OSC_INTERNAL_RC_CLK_DIV4_OUT = 3'h5,
    OSC_EXT_RC_IO          = 3'h6,
    OSC_EXT_RC_CLK_DIV4_OUT      = 3'h7
  } cwcs_osc_t;

  // Clock source driving the system clock mux
  typedef enum logic [3:0] {
    SRC_CRYSTAL = 4'h1,
    SRC_EXT_CLK = 4'h2,
    SRC_INT_RC  = 4'h4,
    SRC_EXT_RC  = 4'h8
  } cwcs_src_t;

  // Reset sequencer states
  typedef enum logic [3:0] {
    ST_RESET   = 4'h1,
    ST_PWR_DLY = 4'h2,
    ST_OSC_DLY = 4'h4,
    ST_RUN     = 4'h8
  } cwcs_state_t;

  // Decoded configuration fields
  typedef struct packed {
    logic        code_protect;
    logic [1:0]  brownout_voltage_select;
    logic        brownout_reset_enable;
    logic        reset_pin_select;
    logic        power_delay_enable_n;
    logic        watchdog_enable;
    cwcs_osc_t   osc_select;
  } cwcs_cfg_t;

  // Pin control for the two oscillator pins
  typedef struct packed {
    logic osc_in_is_io;
    logic osc_out_is_io;
    logic osc_out_drive;
    logic osc_out_oe;
  } cwcs_pins_t;

  // ==========================================================================
  // Timing at 10 MHz
  localparam int CLK_HZ           = 10_000_000;
  localparam int PWR_DLY_MS       = 72;
  localparam int PWR_DLY_CYC      = PWR_DLY_MS * (CLK_HZ / 1000);
  localparam int OSC_START_CYC    = 1024;
  localparam int INT_RC_HZ        = 4_000_000;
  localparam int SLOW_RC_HZ       = 37_000;
  localparam int DIV4             = 4;
  localparam int INT_RC_HALF_CYC  = (CLK_HZ / INT_RC_HZ) / 2 > 0 ? (CLK_HZ / INT_RC_HZ) / 2 : 1;
  localparam int SLOW_RC_HALF_CYC = (CLK_HZ / SLOW_RC_HZ) / 2;
  localparam int CNT_W            = 20;

endpackage
`default_nettype wire

// File: logic/cwcs_rc_osc.sv
// Internal oscillator model: dual-speed toggler stopped during reset
`timescale 1ns/1ps
`default_nettype none
module cwcs_rc_osc
  import cwcs_pkg::*;
(
  input  wire logic clk,         // System clock
  input  wire logic reset_n,     // Async reset, active low
  input  wire logic clk_en,      // Clock enable
  input  wire logic run,         // Oscillator allowed to run
  input  wire logic slow,        // Slow speed selected
  output logic      osc_out      // Oscillator output
);

  logic [CNT_W-1:0] half_reg;
  logic [CNT_W-1:0] limit;

  assign limit = slow ? CNT_W'(SLOW_RC_HALF_CYC - 1) : CNT_W'(INT_RC_HALF_CYC - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half_reg <= '0;
      osc_out  <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        half_reg <= '0;
        osc_out  <= 1'b0;
      end else if (half_reg >= limit) begin
        half_reg <= '0;
        osc_out  <= ~osc_out;
      end else begin
        half_reg <= half_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: logic/cwcs_top.sv
// Configuration word decode, reset timers and system clock source select
// Summary of operation
// - Configuration word at 2007h; programmed bit reads 0, unprogrammed reads 1.
// - Space 2000h-3FFFh reachable only in programming mode.
// - Code protect pairs 13:12 and 9:8; all zero means memory protected.
// - Bits 11-10 choose brown-out trip level 4.5/4.2/2.7/2.5 V.
// - Bit 7 is unimplemented and always reads 1.
// - Bit 6 enables brown-out reset circuitry.
// - Bit 5 set makes pin the reset input, else digital input, reset inactive.
// - Bit 4 low enables the power-up delay timer.
// - Brown-out enable forces the power-up delay timer on.
// - Bit 3 enables watchdog; nothing else can turn it off.
// - Codes 000-010 select crystals on both pins, 011 external clock.
// - Codes 100-111 select internal or resistor RC, second pin I/O or clock out.
// - External clock mode takes clock on first pin, frees second pin.
// - Resistor oscillator stops during reset.
// - Internal RC gives nominal 4 MHz and stops during reset; with the 10 MHz clk the model toggles every cycle, giving 5 MHz.
// - Clock output drives oscillator frequency divided by 4.
// - Clock output held low during reset.
// - Power-up delay holds reset 72 ms, only after power-on or brown-out.
// - Sleep is left on external reset, watchdog wake or enabled interrupt.
// - Watchdog runs from its own oscillator, independent of system clock.
// - Start-up timer holds 1024 first-pin cycles in crystal modes only.
// - Speed select toggles RC oscillator between normal and 37 kHz.
`timescale 1ns/1ps
`default_nettype none
module cwcs_top
  import cwcs_pkg::*;
#(
  parameter int PWR_DLY_CYCLES = PWR_DLY_CYC
)(
  input  wire logic                 clk,               // System clock, 10 MHz
  input  wire logic                 reset_n,           // Async reset, active low
  input  wire logic                 clk_en,            // Clock enable, freezes state
  input  wire logic                 prog_mode,         // Programming mode active
  input  wire logic                 prog_wr,           // Programmer write strobe
  input  wire logic [13:0]          prog_addr,         // Programmer address
  input  wire logic [13:0]          prog_wdata,        // Programmer write data
  output logic      [13:0]          prog_rdata,        // Programmer read data
  input  wire logic                 power_up_event,    // Power-on or brown-out reset pulse
  input  wire logic                 wake_from_sleep,   // Wake from sleep, restarts start-up timer
  input  wire logic                 sleeping,          // Device is in sleep
  input  wire logic                 watchdog_wake,     // Watchdog wake-up event
  input  wire logic                 irq_enabled_pend,  // Enabled interrupt pending
  input  wire logic                 speed_select,      // Power control slow/fast bit, 1 = fast
  input  wire logic                 osc_pin_in_i,      // First oscillator pin level
  input  wire logic                 external_reset_n_i,// Shared reset pin level
  output cwcs_cfg_t                 cfg,               // Decoded configuration
  output cwcs_src_t                 clk_source,        // Selected clock source
  output cwcs_pins_t                pins,              // Oscillator pin functions
  output logic      [3:0]           brownout_trip_level,// One-hot trip level
  output logic                      brownout_enable,   // Brown-out circuitry enable
  output logic                      watchdog_run,      // Watchdog enable
  output logic                      watchdog_own_osc,  // Watchdog uses its own oscillator
  output logic                      power_delay_timer_en, // Power-up delay enabled
  output logic                      core_reset_n,      // Reset to core, active low
  output logic                      sleep_exit,        // Leave sleep, registered level, high while sleeping with a wake condition present
  output logic                      sys_clk_tick       // System clock from RC oscillator
);

  // ==========================================================================
  // Configuration storage
  logic [13:0] cfg_word_reg;
  logic        prog_hit;
  logic        in_cfg_space;

  assign in_cfg_space = (prog_addr >= CFG_SPACE_LO) && (prog_addr <= CFG_SPACE_HI);
  assign prog_hit     = prog_mode && in_cfg_space && (prog_addr == CFG_WORD_ADDR);

  // Programming only clears bits, as in an EPROM cell
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_word_reg <= CFG_ERASED;
    end else if (clk_en && prog_hit && prog_wr) begin
      cfg_word_reg <= cfg_word_reg & prog_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_rdata <= 14'h0000;
    end else if (clk_en) begin
      if (prog_hit) begin
        prog_rdata <= cfg_word_reg | (14'h0001 << UNIMPL_BIT);
      end else begin
        prog_rdata <= 14'h0000;
      end
    end
  end

  // ==========================================================================
  // Decode, sampled while the core is held in reset
  cwcs_cfg_t cfg_next;

  always_comb begin
    cfg_next.code_protect = (cfg_word_reg[CP_HI_MSB:CP_HI_LSB] == 2'h0)
                          && (cfg_word_reg[CP_LO_MSB:CP_LO_LSB] == 2'h0);
    cfg_next.brownout_voltage_select = cfg_word_reg[BROWNOUT_VOLTAGE_SELECT_MSB:BROWNOUT_VOLTAGE_SELECT_LSB];
    cfg_next.brownout_reset_enable   = cfg_word_reg[BOR_EN_BIT];
    cfg_next.reset_pin_select        = cfg_word_reg[RST_PIN_BIT];
    cfg_next.power_delay_enable_n    = cfg_word_reg[PWR_DLY_N_BIT];
    cfg_next.watchdog_enable         = cfg_word_reg[WDOG_EN_BIT];
    cfg_next.osc_select              = cwcs_osc_t'(cfg_word_reg[OSC_MSB:OSC_LSB]);
  end

  cwcs_state_t state_reg;
  logic        in_reset;

  assign in_reset = (state_reg != ST_RUN);

  // Held constant while running outside programming mode so no field moves under live logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= '0;
    end else if (clk_en && (in_reset || prog_mode)) begin
      cfg <= cfg_next;
    end
  end

  // ==========================================================================
  // Enables
  always_comb begin
    unique case (cfg.brownout_voltage_select)
      BOR_TRIP_4V5: brownout_trip_level = 4'h1;
      BOR_TRIP_4V2: brownout_trip_level = 4'h2;
      BOR_TRIP_2V7: brownout_trip_level = 4'h4;
      BOR_TRIP_2V5: brownout_trip_level = 4'h8;
    endcase
  end

  assign brownout_enable      = cfg.brownout_reset_enable;
  assign power_delay_timer_en = !cfg.power_delay_enable_n || cfg.brownout_reset_enable;
  assign watchdog_run         = cfg.watchdog_enable;
  assign watchdog_own_osc     = 1'b1;

  // ==========================================================================
  // Clock source and pin functions
  logic crystal_mode;
  logic rc_mode;
  logic clk_div4_out_mode;

  assign crystal_mode = (cfg.osc_select == OSC_LOW_POWER_CRYSTAL) || (cfg.osc_select == OSC_STD_CRYSTAL)
                      || (cfg.osc_select == OSC_HIGH_SPEED_CRYSTAL);
  assign rc_mode      = cfg.osc_select[2];
  assign clk_div4_out_mode  = rc_mode && cfg.osc_select[0];

  always_comb begin
    unique case (cfg.osc_select)
      OSC_LOW_POWER_CRYSTAL, OSC_STD_CRYSTAL, OSC_HIGH_SPEED_CRYSTAL: clk_source = SRC_CRYSTAL;
      OSC_EXT_CLOCK_IN:                                                clk_source = SRC_EXT_CLK;
      OSC_INTERNAL_RC_IO, OSC_INTERNAL_RC_CLK_DIV4_OUT:                      clk_source = SRC_INT_RC;
      OSC_EXT_RC_IO, OSC_EXT_RC_CLK_DIV4_OUT:                                clk_source = SRC_EXT_RC;
    endcase
  end

  // ==========================================================================
  // Pin synchronisers: change counts once stages two and three agree
  logic [2:0] osc_in_sync;
  logic [2:0] rst_pin_sync;
  logic       osc_in_level;
  logic       osc_in_prev;
  logic       rst_pin_level;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_in_sync  <= 3'h0;
      rst_pin_sync <= 3'h7;
    end else if (clk_en) begin
      osc_in_sync  <= {osc_in_sync[1:0], osc_pin_in_i};
      rst_pin_sync <= {rst_pin_sync[1:0], external_reset_n_i};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_in_level  <= 1'b0;
      osc_in_prev   <= 1'b0;
      rst_pin_level <= 1'b1;
    end else if (clk_en) begin
      if (osc_in_sync[2] == osc_in_sync[1]) begin
        osc_in_level <= osc_in_sync[1];
      end
      if (rst_pin_sync[2] == rst_pin_sync[1]) begin
        rst_pin_level <= rst_pin_sync[1];
      end
      osc_in_prev <= osc_in_level;
    end
  end

  logic ext_reset_active;
  logic osc_in_rise;

  assign ext_reset_active = cfg.reset_pin_select && !rst_pin_level;
  assign osc_in_rise      = osc_in_level && !osc_in_prev;

  // ==========================================================================
  // Reset sequencer: power-up delay then start-up timer
  logic [CNT_W-1:0] tmr_reg;
  logic             osc_dly_pending_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_dly_pending_reg <= 1'b1;
    end else if (clk_en) begin
      if (power_up_event || wake_from_sleep) begin
        osc_dly_pending_reg <= 1'b1;
      end else if (state_reg == ST_RUN) begin
        osc_dly_pending_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_PWR_DLY;
      tmr_reg   <= '0;
    end else if (clk_en) begin
      if (power_up_event) begin
        state_reg <= ST_PWR_DLY;
        tmr_reg   <= '0;
      end else begin
        unique case (state_reg)
          ST_PWR_DLY: begin
            if (!power_delay_timer_en || tmr_reg >= CNT_W'(PWR_DLY_CYCLES - 1)) begin
              state_reg <= ST_OSC_DLY;
              tmr_reg   <= '0;
            end else begin
              tmr_reg <= tmr_reg + 1'b1;
            end
          end
          ST_OSC_DLY: begin
            if (!crystal_mode || !osc_dly_pending_reg || tmr_reg >= CNT_W'(OSC_START_CYC)) begin
              state_reg <= ST_RESET;
              tmr_reg   <= '0;
            end else if (osc_in_rise) begin
              tmr_reg <= tmr_reg + 1'b1;
            end
          end
          ST_RESET: begin
            if (!ext_reset_active) begin
              state_reg <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (ext_reset_active) begin
              state_reg <= ST_RESET;
            end else if (wake_from_sleep && crystal_mode) begin
              state_reg <= ST_OSC_DLY;
              tmr_reg   <= '0;
            end
          end
          default: begin
            state_reg <= ST_PWR_DLY;
            tmr_reg   <= '0;
          end
        endcase
      end
    end
  end

  assign core_reset_n = !in_reset;

  // ==========================================================================
  // Sleep exit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_exit <= 1'b0;
    end else if (clk_en) begin
      sleep_exit <= sleeping && (ext_reset_active || watchdog_wake || irq_enabled_pend);
    end
  end

  // ==========================================================================
  // RC oscillator and divided clock output
  logic rc_clk;
  logic rc_prev_reg;
  logic [1:0] div_reg;

  cwcs_rc_osc u_rc_osc (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .run     (rc_mode && !in_reset),
    .slow    (!speed_select),
    .osc_out (rc_clk)
  );

  // Gated so the tick is low from the first reset cycle, before the toggler stops
  assign sys_clk_tick = rc_clk && !in_reset;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_prev_reg <= 1'b0;
      div_reg     <= 2'h0;
    end else if (clk_en) begin
      rc_prev_reg <= rc_clk;
      if (in_reset) begin
        div_reg <= 2'h0;
      end else if (rc_clk && !rc_prev_reg) begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end

  always_comb begin
    pins.osc_in_is_io  = (cfg.osc_select == OSC_INTERNAL_RC_IO) || (cfg.osc_select == OSC_INTERNAL_RC_CLK_DIV4_OUT);
    pins.osc_out_is_io = (cfg.osc_select == OSC_EXT_CLOCK_IN) || (rc_mode && !clk_div4_out_mode);
    pins.osc_out_oe    = clk_div4_out_mode;
    pins.osc_out_drive = clk_div4_out_mode && !in_reset && div_reg[1];
  end

endmodule
`default_nettype wire

// File: tb/cwcs_xtal_model.sv
// Crystal or external clock source seen on the first oscillator pin
`timescale 1ns/1ps
`default_nettype none
module cwcs_xtal_model #(
  parameter int HALF_NS = 170
)(
  input  wire logic run,     // Source fitted and oscillating
  output logic      osc_pin  // First oscillator pin level
);
  initial osc_pin = 1'b0;
  // Phase unrelated to clk; a missing source leaves the pin low
  always begin
    #(HALF_NS);
    osc_pin = run ? ~osc_pin : 1'b0;
  end
endmodule
`default_nettype wire

// File: tb/cwcs_monitor.sv
// Concurrent checks on the configuration decode and clock select ports
`timescale 1ns/1ps
`default_nettype none
module cwcs_monitor
  import cwcs_pkg::*;
(
  input wire logic        clk,                  // System clock
  input wire logic        reset_n,              // Async reset, active low
  input wire logic        prog_mode,            // Programming mode
  input wire logic [13:0] prog_addr,            // Programmer address
  input wire logic [13:0] prog_rdata,           // Programmer read data
  input wire logic        power_up_event,       // Power-up reset pulse
  input wire logic        wake_from_sleep,      // Wake pulse
  input wire logic        sleeping,             // Sleep level
  input wire logic        watchdog_wake,        // Watchdog wake
  input wire logic        irq_enabled_pend,     // Interrupt pending
  input wire cwcs_cfg_t   cfg,                  // Decoded fields
  input wire cwcs_src_t   clk_source,           // Clock source
  input wire cwcs_pins_t  pins,                 // Pin functions
  input wire logic [3:0]  brownout_trip_level,  // Trip level
  input wire logic        brownout_enable,      // Brown-out enable
  input wire logic        watchdog_run,         // Watchdog enable
  input wire logic        watchdog_own_osc,     // Watchdog own oscillator
  input wire logic        power_delay_timer_en, // Power delay enable
  input wire logic        core_reset_n,         // Core reset
  input wire logic        sleep_exit,           // Leave sleep
  input wire logic        sys_clk_tick          // RC clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Sequences and properties
  function automatic logic [3:0] src_of(input logic [2:0] o);
    return o < 3 ? SRC_CRYSTAL : o == 3 ? SRC_EXT_CLK : o < 6 ? SRC_INT_RC : SRC_EXT_RC;
  endfunction
  logic rc_mode;
  logic out_mode;
  assign rc_mode  = cfg.osc_select[2];
  assign out_mode = cfg.osc_select[2] && cfg.osc_select[0];
  sequence s_word_rd; prog_mode && prog_addr == CFG_WORD_ADDR; endsequence
  sequence s_running; (core_reset_n && !prog_mode) [*3]; endsequence
  sequence s_wake_req; sleeping && (watchdog_wake || irq_enabled_pend); endsequence
  property p_word_rd; s_word_rd |=> prog_rdata[UNIMPL_BIT]; endproperty
  property p_space; !prog_mode |=> prog_rdata == 14'h0; endproperty
  property p_src; clk_source == src_of(cfg.osc_select); endproperty
  property p_ext; cfg.osc_select == OSC_EXT_CLOCK_IN |-> pins.osc_out_is_io && !pins.osc_in_is_io; endproperty
  property p_bor; brownout_enable == cfg.brownout_reset_enable; endproperty
  property p_pwr; power_delay_timer_en == (!cfg.power_delay_enable_n || cfg.brownout_reset_enable); endproperty
  property p_wdog; watchdog_run == cfg.watchdog_enable && watchdog_own_osc; endproperty
  property p_trip; $onehot(brownout_trip_level); endproperty
  property p_rc_stop; !core_reset_n && !$past(core_reset_n) && rc_mode |-> $stable(sys_clk_tick); endproperty
  property p_out_low; !core_reset_n && !$past(core_reset_n) && out_mode |-> !pins.osc_out_drive; endproperty
  property p_hold; s_running |-> $stable(cfg); endproperty
  property p_sleep; s_wake_req |=> sleep_exit; endproperty
  property p_pin;
    core_reset_n && !cfg.reset_pin_select && !prog_mode && !power_up_event && !wake_from_sleep
      && !$past(power_up_event) && !$past(wake_from_sleep) |=> core_reset_n;
  endproperty
  // ==========================================================================
  // Assertions
  a_word_rd: assert property (p_word_rd) else $error("unused bit not read as one");
  a_space: assert property (p_space) else $error("word readable outside programming");
  a_src: assert property (p_src) else $error("clock source decode wrong");
  a_ext: assert property (p_ext) else $error("external clock pin use wrong");
  a_bor: assert property (p_bor) else $error("brown-out enable wrong");
  a_pwr: assert property (p_pwr) else $error("power delay enable wrong");
  a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");
  a_trip: assert property (p_trip) else $error("trip level not one-hot");
  a_rc_stop: assert property (p_rc_stop) else $error("RC clock runs in reset");
  a_out_low: assert property (p_out_low) else $error("clock out not low in reset");
  a_hold: assert property (p_hold) else $error("fields changed while running");
  a_sleep: assert property (p_sleep) else $error("no sleep exit on wake");
  a_pin: assert property (p_pin) else $error("reset from disabled pin");
endmodule
bind cwcs_top cwcs_monitor i_mon (
  .clk(clk), .reset_n(reset_n), .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
  .power_up_event(power_up_event), .wake_from_sleep(wake_from_sleep), .sleeping(sleeping),
  .watchdog_wake(watchdog_wake), .irq_enabled_pend(irq_enabled_pend), .cfg(cfg), .clk_source(clk_source),
  .pins(pins), .brownout_trip_level(brownout_trip_level), .brownout_enable(brownout_enable),
  .watchdog_run(watchdog_run), .watchdog_own_osc(watchdog_own_osc), .power_delay_timer_en(power_delay_timer_en),
  .core_reset_n(core_reset_n), .sleep_exit(sleep_exit), .sys_clk_tick(sys_clk_tick)
);
`default_nettype wire

// File: tb/cwcs_top_tb.sv
// Self-checking bench for configuration decode and clock source select
`timescale 1ns/1ps
`default_nettype none
module cwcs_top_tb;
  import cwcs_pkg::*;
  localparam int PWR     = 20;
  localparam int HALF_NS = 260; // Each pin level spans at least two rising clk edges
  localparam int CYC_MAX = 40000;
  logic        clk = 1'b0, reset_n = 1'b0, prog_mode = 1'b0, prog_wr = 1'b0;
  logic [13:0] prog_addr = 14'h0, prog_wdata = 14'h0, prog_rdata;
  logic        power_up_event = 1'b0, wake_from_sleep = 1'b0, sleeping = 1'b0;
  logic        watchdog_wake = 1'b0, irq_enabled_pend = 1'b0, speed_select = 1'b1;
  logic        osc_pin, external_reset_n_i = 1'b1, xtal_run = 1'b0;
  cwcs_cfg_t   cfg;
  cwcs_src_t   clk_source;
  cwcs_pins_t  pins;
  logic [3:0]  brownout_trip_level;
  logic        brownout_enable, watchdog_run, watchdog_own_osc, power_delay_timer_en;
  logic        core_reset_n, sleep_exit, sys_clk_tick;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  logic [31:0] seed = 32'hfa29f96b;

  always #50 clk = ~clk;

  cwcs_top #(.PWR_DLY_CYCLES(PWR)) i_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .prog_mode(prog_mode), .prog_wr(prog_wr),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .power_up_event(power_up_event),
    .wake_from_sleep(wake_from_sleep), .sleeping(sleeping), .watchdog_wake(watchdog_wake),
    .irq_enabled_pend(irq_enabled_pend), .speed_select(speed_select), .osc_pin_in_i(osc_pin),
    .external_reset_n_i(external_reset_n_i), .cfg(cfg), .clk_source(clk_source), .pins(pins),
    .brownout_trip_level(brownout_trip_level), .brownout_enable(brownout_enable), .watchdog_run(watchdog_run),
    .watchdog_own_osc(watchdog_own_osc), .power_delay_timer_en(power_delay_timer_en),
    .core_reset_n(core_reset_n), .sleep_exit(sleep_exit), .sys_clk_tick(sys_clk_tick)
  );
  cwcs_xtal_model #(.HALF_NS(HALF_NS)) i_xtal (.run(xtal_run), .osc_pin(osc_pin));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(negedge clk);
    prog_addr  = a;
    prog_wdata = d;
    prog_wr    = 1'b1;
    @(negedge clk);
    prog_wr = 1'b0;
  endtask
  task automatic rd(input logic [13:0] a, input logic [13:0] e);
    @(negedge clk);
    prog_addr = a;
    @(negedge clk);
    chk(prog_rdata, e);
  endtask
  // Cycles between two rising edges of the RC tick or the clock out pin
  task automatic per(input logic sel, output int n);
    logic p, c;
    int   k;
    p = 1'b1;
    k = 0;
    n = 0;
    repeat (1000) begin
      @(negedge clk);
      c = sel ? pins.osc_out_drive : sys_clk_tick;
      if (c === 1'b1 && p === 1'b0) k++;
      if (k == 1) n++;
      p = c;
      if (k == 2) break;
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      n_mismatch++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int n, e;
    logic [13:0] w, w1, ex;
    logic [2:0]  o;
    for (int code = 0; code < 8; code++) begin
      o = code[2:0];
      reset_n = 1'b0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      wr(CFG_WORD_ADDR, 14'h0);
      prog_mode = 1'b1;
      wr(14'h2006, 14'h0);
      rd(14'h2006, 14'h0);
      rd(CFG_WORD_ADDR, CFG_ERASED);
      w1 = rnd();
      w1[13:12] = 2'b11;
      w1[9:8] = 2'b11;
      w1[5] = 1'b1;
      w1[2:0] = 3'h7;
      w = rnd();
      w[12] = w[13];
      w[9:8] = {2{w[13]}};
      w[5] = code[0];
      w[2:0] = o;
      wr(CFG_WORD_ADDR, w1);
      wr(CFG_WORD_ADDR, w);
      ex = w & w1;
      rd(CFG_WORD_ADDR, ex | 14'h0080);
      repeat (2) @(negedge clk);
      chk(cfg, {ex[13:12] == 2'b00 && ex[9:8] == 2'b00, ex[11:10], ex[6:0]});
      chk(clk_source, o < 3 ? SRC_CRYSTAL : o == 3 ? SRC_EXT_CLK : o < 6 ? SRC_INT_RC : SRC_EXT_RC);
      if (o >= 3) chk(pins[3:2], {o == 4 || o == 5, o == 3 || o == 4 || o == 6});
      chk(power_delay_timer_en, !ex[4] || ex[6]);
      prog_mode = 1'b0;
      xtal_run = o <= 3;
      power_up_event = 1'b1;
      @(negedge clk);
      power_up_event = 1'b0;
      e = ((!ex[4] || ex[6]) ? PWR : 0) + (o < 3 ? 1024 * 2 * HALF_NS / 100 : 0);
      n = 0;
      while (core_reset_n !== 1'b1 && n < 6000) begin
        @(negedge clk);
        n++;
      end
      chk(n + 4 >= e && n <= e + 12, 1'b1);
      if (o >= 4) begin
        per(1'b0, n);
        chk(n, 2 * INT_RC_HALF_CYC);
        if (code[0]) begin
          per(1'b1, n);
          chk(n, 4 * 2 * INT_RC_HALF_CYC);
        end
        speed_select = 1'b0;
        per(1'b0, n);
        chk(n, 2 * SLOW_RC_HALF_CYC);
        speed_select = 1'b1;
      end
      $display("test osc code %0d done", code);
    end
    // Random sleep traffic; wake relations are judged by the monitor
    repeat (300) begin
      @(negedge clk);
      w = rnd();
      sleeping = w[0];
      watchdog_wake = w[1] & w[2];
      irq_enabled_pend = w[3] & w[4];
      wake_from_sleep = w[5] & w[6] & w[7];
      speed_select = w[8] | w[9];
    end
    {sleeping, watchdog_wake, irq_enabled_pend, wake_from_sleep} = 4'h0;
    $display("test sleep wake done");
    external_reset_n_i = 1'b0;
    repeat (8) @(negedge clk);
    chk(core_reset_n, 1'b0);
    external_reset_n_i = 1'b1;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk(core_reset_n, 1'b1);
    $display("test reset pin done");
    results();
  end
endmodule
`default_nettype wire
